// file: include/reset_boot_map.svh
// Purpose: named offsets, field positions, reset values and counts of the reset/boot block
// Assumes: word addresses on the plain register port, 16-bit data
// Notes:   definitions only
`ifndef RESET_BOOT_MAP_SVH
`define RESET_BOOT_MAP_SVH

// register word addresses
`define RB_ADDR_PULLUP      8'h00
`define RB_ADDR_OSC         8'h01
`define RB_ADDR_STATUS      8'h02

// pull-up disable register fields
`define RB_PUD_RESET        0
`define RB_PUD_BOOTSEL      1
`define RB_PUD_EXTMEM       2
`define RB_PUD_RESET_VAL    3'h0

// oscillator control register fields
`define RB_OSC_LEVEL        0
`define RB_OSC_RESET_VAL    1'h0

// status register fields
`define RB_ST_BOOT_EXT      0
`define RB_ST_EXTMEM_WIDE   1
`define RB_ST_SECURED       2
`define RB_ST_CLK_MODE      3
`define RB_ST_DEBUG_RUN     4

// internal clocks from synchronised reset-source release to internal reset release
`define RB_RELEASE_CYCLES   32

`define RB_SYNC_RESET_VAL   2'h0
`define RB_COUNT_ZERO       8'h00
`define RB_COUNT_ONE        8'h01
`define RB_DATA_ZERO        16'h0000

`endif

// file: include/reset_boot_pkg.sv
// Purpose: state type of the reset/boot block
// Assumes: state is registered as one packed struct
// Notes:   field widths only; values live in reset_boot_map.svh
package reset_boot_pkg;

	typedef struct packed {
		logic [1:0]  rstPinSync;   // external reset pin synchroniser
		logic [1:0]  trstSync;     // test-port reset synchroniser
		logic [1:0]  extBootSync;  // boot select strap synchroniser
		logic [1:0]  extMemSync;   // memory mode strap synchroniser
		logic [1:0]  clkModeSync;  // clock source mode synchroniser
		logic [7:0]  relCount;     // release counter
		logic        chipRstN;     // internal reset, low = in reset
		logic        dbgRstN;      // debug logic reset, low = in reset
		logic [2:0]  pullupDis;    // pull-up disable register
		logic        oscHigh;      // oscillator high-level select
		logic        bootExt;      // latched boot mode
		logic        extMemWide;   // latched memory mode
		logic        secLatched;   // flash security seen at release
		logic [15:0] rdata;        // read data
	} rb_state_t;

endpackage

// file: hw/reset_boot_clock_select.sv
// Purpose: chip reset release, reset output, boot strap capture, pull-up and oscillator bits
// Assumes: rstn is the power-on reset; pins are asynchronous and synchronised here
// Notes:   pin reset takes effect after the two synchroniser stages
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "reset_boot_map.svh"

// What this block does
// - a low external reset pin holds internal reset and the pull-up and oscillator registers in reset
// - internal reset releases synchronously after a fixed internal clock count
// - reset pin alone leaves the debug logic running
// - power-on reset asserts internal reset regardless of the reset pin
// - pull-up disable bit turns off reset pin pull-up; enabled after reset
// - reset output pin follows internal reset at all times
// - high boot select and unsecured flash give external boot, else internal
// - secured flash at reset forces internal boot despite high boot select
// - normally boot internal; memory mode matters only with external boot
// - oscillator high-level select resets to zero, resonator mode
module reset_boot_clock_select
	import reset_boot_pkg::*;
#(
	parameter logic [7:0] RELEASE_CYCLES = 8'(`RB_RELEASE_CYCLES)
) (
	// clock and power-on reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// pins from the board
	input  wire logic        resetPinN,
	input  wire logic        testResetN,
	input  wire logic        extBootPin,
	input  wire logic        extMemModePin,
	input  wire logic        clockSourceMode,
	// on-chip flash security state
	input  wire logic        flashSecured,
	// register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [15:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdata,
	// resets
	output logic             chipResetN,
	output logic             debugResetN,
	output logic             resetOutPin,
	// pad pull-up enables
	output logic             resetPullupEn,
	output logic             bootSelPullupEn,
	output logic             extMemPullupEn,
	// oscillator and boot mode
	output logic             oscHighLevelSelect,
	output logic             bootExternal,
	output logic             extMemWide
);

	localparam logic [7:0] LAST_COUNT = RELEASE_CYCLES - `RB_COUNT_ONE;

	rb_state_t s_r;
	rb_state_t s_nxt;
	logic      pinHeld;

	assign pinHeld = ~s_r.rstPinSync[1];

	// next state: synchronisers, release counter, strap capture, registers
	always_comb begin
		s_nxt = s_r;
		// first stages feed only the second stages
		s_nxt.rstPinSync  = {s_r.rstPinSync[0], resetPinN};
		s_nxt.trstSync    = {s_r.trstSync[0], testResetN};
		s_nxt.extBootSync = {s_r.extBootSync[0], extBootPin};
		s_nxt.extMemSync  = {s_r.extMemSync[0], extMemModePin};
		s_nxt.clkModeSync = {s_r.clkModeSync[0], clockSourceMode};
		// debug reset follows only the test-port reset, never the reset pin
		s_nxt.dbgRstN     = s_r.trstSync[1];
		s_nxt.rdata       = `RB_DATA_ZERO;
		if (pinHeld) begin
			// pin low: restart the whole sequence and reset the registers
			s_nxt.relCount  = `RB_COUNT_ZERO;
			s_nxt.chipRstN  = 1'b0;
			s_nxt.pullupDis = `RB_PUD_RESET_VAL;
			s_nxt.oscHigh   = `RB_OSC_RESET_VAL;
		end else if (!s_r.chipRstN) begin
			if (s_r.relCount == LAST_COUNT) begin
				// release and capture straps in the same edge
				s_nxt.chipRstN   = 1'b1;
				s_nxt.secLatched = flashSecured;
				// secured flash overrides a high boot select
				s_nxt.bootExt    = s_r.extBootSync[1] & ~flashSecured;
				// memory mode only counts when booting externally
				s_nxt.extMemWide = s_r.extBootSync[1] & ~flashSecured
					& s_r.extMemSync[1];
			end else begin
				s_nxt.relCount = s_r.relCount + `RB_COUNT_ONE;
			end
		end else begin
			// software access only while out of reset; writes in reset are dropped
			if (regWr) begin
				unique case (regAddr)
					`RB_ADDR_PULLUP: s_nxt.pullupDis = regWdata[2:0];
					`RB_ADDR_OSC:    s_nxt.oscHigh   = regWdata[`RB_OSC_LEVEL];
					default:         ;
				endcase
			end
			if (regRd) begin
				unique case (regAddr)
					`RB_ADDR_PULLUP: s_nxt.rdata[2:0] = s_r.pullupDis;
					`RB_ADDR_OSC:    s_nxt.rdata[`RB_OSC_LEVEL] = s_r.oscHigh;
					`RB_ADDR_STATUS: begin
						s_nxt.rdata[`RB_ST_BOOT_EXT]    = s_r.bootExt;
						s_nxt.rdata[`RB_ST_EXTMEM_WIDE] = s_r.extMemWide;
						s_nxt.rdata[`RB_ST_SECURED]     = s_r.secLatched;
						s_nxt.rdata[`RB_ST_CLK_MODE]    = s_r.clkModeSync[1];
						s_nxt.rdata[`RB_ST_DEBUG_RUN]   = s_r.dbgRstN;
					end
					default:         ; // unmapped reads return zero
				endcase
			end
		end
	end

	// power-on reset forces everything into reset at once
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_r.rstPinSync <= `RB_SYNC_RESET_VAL;
			s_r.trstSync   <= `RB_SYNC_RESET_VAL;
			s_r.extBootSync <= `RB_SYNC_RESET_VAL;
			s_r.extMemSync <= `RB_SYNC_RESET_VAL;
			s_r.clkModeSync <= `RB_SYNC_RESET_VAL;
			s_r.relCount   <= `RB_COUNT_ZERO;
			s_r.chipRstN   <= 1'b0;
			s_r.dbgRstN    <= 1'b0;
			s_r.pullupDis  <= `RB_PUD_RESET_VAL;
			s_r.oscHigh    <= `RB_OSC_RESET_VAL;
			s_r.bootExt    <= 1'b0;
			s_r.extMemWide <= 1'b0;
			s_r.secLatched <= 1'b0;
			s_r.rdata      <= `RB_DATA_ZERO;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from state flops
	assign chipResetN         = s_r.chipRstN;
	assign resetOutPin        = s_r.chipRstN;
	assign debugResetN        = s_r.dbgRstN;
	assign resetPullupEn      = ~s_r.pullupDis[`RB_PUD_RESET];
	assign bootSelPullupEn    = ~s_r.pullupDis[`RB_PUD_BOOTSEL];
	assign extMemPullupEn     = ~s_r.pullupDis[`RB_PUD_EXTMEM];
	assign oscHighLevelSelect = s_r.oscHigh;
	assign bootExternal       = s_r.bootExt;
	assign extMemWide         = s_r.extMemWide;
	assign regRdata           = s_r.rdata;

	// checks on the reset sequence and register effects
	AST_PIN_HOLDS: assert property (@(posedge clk) disable iff (!rstn)
		!s_r.rstPinSync[1] |=> !chipResetN && !oscHighLevelSelect)
		else $error("reset pin low did not hold internal reset");

	AST_RELEASE_COUNT: assert property (@(posedge clk) disable iff (!rstn)
		$rose(chipResetN) |-> $past(s_r.relCount) == LAST_COUNT && $past(s_r.rstPinSync[1]))
		else $error("internal reset released at wrong count");

	AST_POR_ASSERTS: assert property (@(posedge clk)
		$rose(rstn) |-> !chipResetN && !resetOutPin)
		else $error("internal reset not asserted after power-on");

	AST_DEBUG_KEPT: assert property (@(posedge clk) disable iff (!rstn)
		(s_r.trstSync[1] && !s_r.rstPinSync[1]) |=> debugResetN)
		else $error("debug logic reset by reset pin alone");

	AST_RESET_OUT: assert property (@(posedge clk)
		resetOutPin == chipResetN)
		else $error("reset output differs from internal reset");

	AST_PULLUP_WRITE: assert property (@(posedge clk) disable iff (!rstn)
		(regWr && regAddr == `RB_ADDR_PULLUP && chipResetN && s_r.rstPinSync[1])
		|=> resetPullupEn == !$past(regWdata[`RB_PUD_RESET]))
		else $error("pull-up disable write did not take effect");

	AST_PULLUP_RESET: assert property (@(posedge clk) disable iff (!rstn)
		!chipResetN |-> resetPullupEn && bootSelPullupEn && extMemPullupEn)
		else $error("pull-up not enabled during reset");

	AST_BOOT_SELECT: assert property (@(posedge clk) disable iff (!rstn)
		$rose(chipResetN) |-> bootExternal == ($past(s_r.extBootSync[1]) && !$past(flashSecured)))
		else $error("boot mode captured wrongly");

	AST_SECURE_INTERNAL: assert property (@(posedge clk) disable iff (!rstn)
		($rose(chipResetN) && $past(flashSecured)) |-> !bootExternal ##1 !bootExternal)
		else $error("secured flash allowed external boot");

	AST_EXTMEM_ONLY_EXT: assert property (@(posedge clk) disable iff (!rstn)
		extMemWide |-> bootExternal)
		else $error("memory mode set while booting internally");

	AST_OSC_DEFAULT: assert property (@(posedge clk) disable iff (!rstn)
		$rose(chipResetN) |-> !oscHighLevelSelect)
		else $error("oscillator select not zero at release");

	// the reset output must already be low while power-on reset is applied
	AST_POR_PIN_LOW: assert property (@(posedge clk)
		!rstn |-> !resetOutPin)
		else $error("reset output high during power-on reset");

	AST_DEBUG_TRACKS_TEST: assert property (@(posedge clk) disable iff (!rstn)
		!s_r.trstSync[1] |=> !debugResetN)
		else $error("debug logic left running under test-port reset");

	AST_OSC_IN_RESET: assert property (@(posedge clk) disable iff (!rstn)
		!chipResetN |-> !oscHighLevelSelect)
		else $error("oscillator select set while in reset");

	// a read during reset must not leak register contents
	AST_READ_IN_RESET: assert property (@(posedge clk) disable iff (!rstn)
		(regRd && !chipResetN) |=> regRdata == `RB_DATA_ZERO)
		else $error("register read answered while in reset");

	AST_STRAP_PULLUP_WRITE: assert property (@(posedge clk) disable iff (!rstn)
		(regWr && regAddr == `RB_ADDR_PULLUP && chipResetN && s_r.rstPinSync[1])
		|=> bootSelPullupEn == !$past(regWdata[`RB_PUD_BOOTSEL])
			&& extMemPullupEn == !$past(regWdata[`RB_PUD_EXTMEM]))
		else $error("strap pull-up disable write did not take effect");

endmodule

// file: bench/board_partner.sv
// Purpose: board side model: reset source, boot straps, clock source pin
// Assumes: bench steers the controls just after a rising edge
// Notes:   pins follow controls at once, so the model adds no hidden cycle
`timescale 1ns/100ps
module board_partner (
	// controls from the bench
	input  wire logic fullRst,
	input  wire logic pinRst,
	input  wire logic bootHigh,
	input  wire logic memHigh,
	input  wire logic extClock,
	input  wire logic secure,
	// board pins
	output logic      resetPinN,
	output logic      testResetN,
	output logic      extBootPin,
	output logic      extMemModePin,
	output logic      clockSourceMode,
	output logic      flashSecured
);
	// full reset pulls both lines together; pin reset spares the test port
	assign resetPinN = ~(fullRst | pinRst);
	assign testResetN = ~fullRst;
	// straps are static levels driven hard, so pull-ups may be off
	assign extBootPin = bootHigh;
	assign extMemModePin = memHigh;
	// an external clock on the output pin needs the mode pin high
	assign clockSourceMode = extClock;
	assign flashSecured = secure;
endmodule

// file: bench/tb_reset_boot_clock_select.sv
// Purpose: self-checking bench for reset release, straps, pull-up and oscillator bits
// Assumes: short release count so every reset pulse stays brief
// Notes:   expectations come from the release count and strap truth table
`timescale 1ns/100ps
`include "reset_boot_map.svh"
module tb_reset_boot_clock_select;
	import reset_boot_pkg::*;
	localparam int RC = 4;
	logic clk, rstn, regWr, regRd, fullRst, pinRst, bootHigh, memHigh, extClock, secure;
	logic [7:0]  regAddr;
	logic [15:0] regWdata, regRdata, rd;
	logic resetPinN, testResetN, extBootPin, extMemModePin, clockSourceMode, flashSecured;
	logic chipResetN, debugResetN, resetOutPin, resetPullupEn, bootSelPullupEn, extMemPullupEn;
	logic oscHighLevelSelect, bootExternal, extMemWide;
	int miscompares, totalChecks, cycles, n;

	board_partner board_partner_i (.fullRst(fullRst), .pinRst(pinRst), .bootHigh(bootHigh),
		.memHigh(memHigh), .extClock(extClock), .secure(secure), .resetPinN(resetPinN),
		.testResetN(testResetN), .extBootPin(extBootPin), .extMemModePin(extMemModePin),
		.clockSourceMode(clockSourceMode), .flashSecured(flashSecured));
	reset_boot_clock_select #(.RELEASE_CYCLES(8'(RC))) reset_boot_clock_select_i (
		.clk(clk), .rstn(rstn), .resetPinN(resetPinN), .testResetN(testResetN),
		.extBootPin(extBootPin), .extMemModePin(extMemModePin),
		.clockSourceMode(clockSourceMode), .flashSecured(flashSecured), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.chipResetN(chipResetN), .debugResetN(debugResetN), .resetOutPin(resetOutPin),
		.resetPullupEn(resetPullupEn), .bootSelPullupEn(bootSelPullupEn),
		.extMemPullupEn(extMemPullupEn), .oscHighLevelSelect(oscHighLevelSelect),
		.bootExternal(bootExternal), .extMemWide(extMemWide));

	// 50 MHz clock
	always #10 clk = ~clk;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", totalChecks, miscompares);
		if (miscompares == 0 && totalChecks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic regWrite(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		#1;
	endtask

	task automatic regRead(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1;
		d = regRdata;
	endtask

	// counts edges from a release edge until the internal reset lifts
	task automatic waitRelease();
		n = 0;
		#1;
		while (chipResetN !== 1'b1 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		check(16'(n), 16'(2 + RC));
		check({15'h0, resetOutPin}, 16'h0001);
		check({13'h0, resetPullupEn, bootSelPullupEn, extMemPullupEn}, 16'h0007);
		check({15'h0, oscHighLevelSelect}, 16'h0000);
	endtask

	// power-on reset asserts alone, with the reset pin left high
	task automatic tPowerOn();
		@(posedge clk);
		rstn <= 1'b0;
		#1;
		check({14'h0, chipResetN, resetOutPin}, 16'h0000);
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		waitRelease();
	endtask

	// reset pin pulse; a write during reset must be dropped
	task automatic tPinReset(input logic full);
		@(posedge clk);
		pinRst <= ~full;
		fullRst <= full;
		repeat (3) @(posedge clk);
		#1;
		check({14'h0, chipResetN, resetOutPin}, 16'h0000);
		check({15'h0, debugResetN}, {15'h0, ~full});
		regWrite(`RB_ADDR_OSC, 16'h0001);
		check({15'h0, oscHighLevelSelect}, 16'h0000);
		regRead(`RB_ADDR_OSC, rd);
		check(rd, 16'h0000);
		// release the pins on a clock edge, like every other input
		@(posedge clk);
		pinRst <= 1'b0;
		fullRst <= 1'b0;
		waitRelease();
		check({15'h0, debugResetN}, 16'h0001);
	endtask

	task automatic tRegs();
		regWrite(`RB_ADDR_PULLUP, 16'hffff);
		check({13'h0, resetPullupEn, bootSelPullupEn, extMemPullupEn}, 16'h0000);
		regRead(`RB_ADDR_PULLUP, rd);
		check(rd, 16'h0007);
		regWrite(`RB_ADDR_OSC, 16'h0001);
		check({15'h0, oscHighLevelSelect}, 16'h0001);
		regRead(`RB_ADDR_OSC, rd);
		check(rd, 16'h0001);
		regWrite(`RB_ADDR_OSC, 16'h0000);
		check({15'h0, oscHighLevelSelect}, 16'h0000);
		regWrite(8'h7f, 16'hffff);
		regRead(8'h7f, rd);
		check(rd, 16'h0000);
		regWrite(`RB_ADDR_OSC, 16'h0001);
	endtask

	// every strap and security combination, latched at release
	task automatic tBootModes();
		logic b, s, m;
		for (int i = 0; i < 8; i++) begin
			b = i[0];
			s = i[1];
			m = i[2];
			@(posedge clk);
			bootHigh <= b;
			secure <= s;
			memHigh <= m;
			extClock <= b;
			tPinReset(1'b0);
			check({14'h0, bootExternal, extMemWide}, {14'h0, b & ~s, b & ~s & m});
			regRead(`RB_ADDR_STATUS, rd);
			check(rd, {11'h0, 1'b1, b, s, b & ~s & m, b & ~s});
		end
	endtask

	// cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			complete_run();
		end
	end

	initial begin
		{clk, regWr, regRd, fullRst, pinRst, bootHigh, memHigh, extClock, secure} = '0;
		{regAddr, regWdata} = '0;
		{miscompares, totalChecks, cycles} = '0;
		// a clean falling edge before the first clock, so no flop starts unknown
		rstn = 1'b1;
		#1;
		rstn = 1'b0;
		tPowerOn();
		tRegs();
		tPinReset(1'b0);
		tRegs();
		tPinReset(1'b1);
		tBootModes();
		tRegs();
		tPowerOn();
		complete_run();
	end
endmodule
